// >>> verilog/channel_status_regs.v
// Status registers of the second clock-synthesis channel, read-only except the interrupt status and mask, reached over APB.
// Assumes loop status inputs are synchronous to sys_clk and driven by the loop logic outside.
//
// Implementation choice: the APB interface to the registers.
`include "status_consts.vh"
module channel_status_regs (
   input wire sys_clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [17:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   input wire sysclk_mult_locked,
   input wire second_analog_loop_cal,
   input wire second_analog_loop_locked,
   input wire second_digital_loop_freq_locked,
   input wire second_digital_loop_phase_locked,
   input wire [1:0] second_digital_loop_ref,
   input wire second_digital_loop_switching,
   input wire second_digital_loop_holdover,
   input wire second_digital_loop_free_run,
   input wire second_digital_loop_slew_limited,
   input wire second_digital_loop_freq_clamped,
   input wire second_digital_loop_history_ready,
   output wire irq
);
   wire [15:0] idx;
   wire access_phase;
   wire wr_en;
   wire rd_en;
   wire update_hit;
   wire known_addr;
   wire [7:0] lock_live;
   wire [7:0] state_live;
   wire [7:0] flags_live;
   wire [7:0] lock_held;
   wire [7:0] state_held;
   wire [7:0] flags_held;
   wire [`IRQ_WIDTH-1:0] event_vec;
   reg [`IRQ_WIDTH-1:0] event_prev_reg;
   reg [`IRQ_WIDTH-1:0] irq_status_reg;
   reg [`IRQ_WIDTH-1:0] irq_status_next;
   reg [`IRQ_WIDTH-1:0] irq_mask_reg;
   reg [31:0] rdata_next;

   assign idx = paddr[17:2];
   assign access_phase = psel & penable;
   assign pready = 1'b1;
   assign wr_en = access_phase & pwrite;
   assign rd_en = access_phase & ~pwrite;
   assign known_addr = (idx == `IDX_UPDATE) || (idx == `IDX_LOCK_STATUS) || (idx == `IDX_LOOP_STATE) ||
                       (idx == `IDX_LOOP_FLAGS) || (idx == `IDX_IRQ_STATUS) || (idx == `IDX_IRQ_MASK);
   assign pslverr = access_phase & ~known_addr;

   // Status only refreshes on an update strobe; reads otherwise return the last snapshot.
   assign update_hit = wr_en & (idx == `IDX_UPDATE) & (pwdata[7:0] == `UPDATE_VALUE);

   assign lock_live[7:5] = 3'h0;
   assign lock_live[`LOCK_CAL_BIT] = second_analog_loop_cal;
   assign lock_live[`LOCK_ANALOG_BIT] = second_analog_loop_locked;
   assign lock_live[`LOCK_FREQ_BIT] = second_digital_loop_freq_locked;
   assign lock_live[`LOCK_PHASE_BIT] = second_digital_loop_phase_locked;
   // Digital loop counts as locked when phase locked.
   assign lock_live[`LOCK_ALL_BIT] = sysclk_mult_locked & second_analog_loop_locked &
                                     second_digital_loop_phase_locked;

   assign state_live[7:5] = 3'h0;
   assign state_live[`STATE_REF_HI:`STATE_REF_LO] = second_digital_loop_ref;
   assign state_live[`STATE_SWITCH_BIT] = second_digital_loop_switching;
   assign state_live[`STATE_HOLD_BIT] = second_digital_loop_holdover;
   assign state_live[`STATE_FREE_BIT] = second_digital_loop_free_run;

   assign flags_live[7:3] = 5'h00;
   assign flags_live[`FLAG_SLEW_BIT] = second_digital_loop_slew_limited;
   assign flags_live[`FLAG_CLAMP_BIT] = second_digital_loop_freq_clamped;
   assign flags_live[`FLAG_HIST_BIT] = second_digital_loop_history_ready;

   status_snapshot #(.WIDTH(24)) snap (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .capture(update_hit),
      .live({flags_live, state_live, lock_live}),
      .held({flags_held, state_held, lock_held})
   );

   // Interrupt events are rising edges of lock loss, holdover entry and the three loop flags.
   assign event_vec = {second_digital_loop_history_ready, second_digital_loop_freq_clamped,
                       second_digital_loop_slew_limited, second_digital_loop_holdover,
                       ~lock_live[`LOCK_ALL_BIT]};

   always @* begin
      irq_status_next = irq_status_reg;
      if (wr_en && idx == `IDX_IRQ_STATUS) begin
         irq_status_next = irq_status_next & ~pwdata[`IRQ_WIDTH-1:0];
      end
      // Set wins over a clear in the same cycle.
      irq_status_next = irq_status_next | (event_vec & ~event_prev_reg);
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         // Loops are unlocked out of reset, so lock loss starts armed and raises no false event.
         event_prev_reg <= `EVENT_PREV_RESET;
         irq_status_reg <= {`IRQ_WIDTH{1'b0}};
         irq_mask_reg <= `IRQ_MASK_RESET;
      end else begin
         event_prev_reg <= event_vec;
         irq_status_reg <= irq_status_next;
         if (wr_en && idx == `IDX_IRQ_MASK) begin
            irq_mask_reg <= pwdata[`IRQ_WIDTH-1:0];
         end
      end
   end

   assign irq = |(irq_status_reg & irq_mask_reg);

   // Status offsets decode only on reads, so writes there have no effect.
   always @* begin
      rdata_next = 32'h0000_0000;
      case (idx)
         `IDX_LOCK_STATUS: rdata_next = {24'h000000, lock_held};
         `IDX_LOOP_STATE: rdata_next = {24'h000000, state_held};
         `IDX_LOOP_FLAGS: rdata_next = {24'h000000, flags_held};
         `IDX_IRQ_STATUS: rdata_next = {27'h0000000, irq_status_reg};
         `IDX_IRQ_MASK: rdata_next = {27'h0000000, irq_mask_reg};
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   // Read data is registered at the setup cycle so it is steady in the access phase.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rdata_next;
      end else if (rd_en) begin
         prdata <= prdata;
      end
   end
endmodule

// >>> verilog/status_consts.vh
// Constants for the second channel status readback block: offsets, fields, strobe values.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef STATUS_CONSTS_VH
`define STATUS_CONSTS_VH
// Printed offsets are indices; the byte address is four times the index.
`define IDX_UPDATE 16'h0005
`define IDX_LOCK_STATUS 16'h0d40
`define IDX_LOOP_STATE 16'h0d41
`define IDX_LOOP_FLAGS 16'h0d42
`define IDX_IRQ_STATUS 16'h0d50
`define IDX_IRQ_MASK 16'h0d51
`define UPDATE_VALUE 8'h01
`define LOCK_CAL_BIT 4
`define LOCK_ANALOG_BIT 3
`define LOCK_FREQ_BIT 2
`define LOCK_PHASE_BIT 1
`define LOCK_ALL_BIT 0
`define STATE_REF_HI 4
`define STATE_REF_LO 3
`define STATE_SWITCH_BIT 2
`define STATE_HOLD_BIT 1
`define STATE_FREE_BIT 0
`define FLAG_SLEW_BIT 2
`define FLAG_CLAMP_BIT 1
`define FLAG_HIST_BIT 0
`define IRQ_WIDTH 5
`define IRQ_MASK_RESET 5'h00
`define EVENT_PREV_RESET 5'h01
`endif

// >>> verilog/status_snapshot.v
// Snapshot register: captures live status bits on an update strobe.
// Assumes live inputs are synchronous to the clock.
module status_snapshot #(
   parameter WIDTH = 8
) (
   input wire sys_clk,
   input wire rst_n,
   input wire capture,
   input wire [WIDTH-1:0] live,
   output reg [WIDTH-1:0] held
);
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         held <= {WIDTH{1'b0}};
      end else if (capture) begin
         held <= live;
      end
   end
endmodule

// >>> tb/channel_status_regs_assertions.sv
// Concurrent checks on the APB readback and status snapshot ports of the status block.
// Assumes it is bound to channel_status_regs, whose port names it shares.
module channel_status_regs_assertions (
   input wire sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq,
   input wire [17:0] paddr,
   input wire [31:0] pwdata, prdata,
   input wire sysclk_mult_locked, second_analog_loop_cal, second_analog_loop_locked,
   input wire second_digital_loop_freq_locked, second_digital_loop_phase_locked,
   input wire [1:0] second_digital_loop_ref,
   input wire second_digital_loop_switching, second_digital_loop_holdover, second_digital_loop_free_run,
   input wire second_digital_loop_slew_limited, second_digital_loop_freq_clamped,
   input wire second_digital_loop_history_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [4:0] lock_live = {second_analog_loop_cal, second_analog_loop_locked, second_digital_loop_freq_locked,
      second_digital_loop_phase_locked,
      sysclk_mult_locked & second_analog_loop_locked & second_digital_loop_phase_locked};
   wire [4:0] state_live = {second_digital_loop_ref, second_digital_loop_switching,
      second_digital_loop_holdover, second_digital_loop_free_run};
   wire [2:0] flag_live = {second_digital_loop_slew_limited, second_digital_loop_freq_clamped,
      second_digital_loop_history_ready};
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_strobe;
      psel && penable && pwrite && pready && paddr == 18'h14 && pwdata[7:0] == 8'h01;
   endsequence
   sequence s_rd(a);
      psel && !penable && !pwrite && paddr == a;
   endsequence
   a_lock_snap: assert property (s_strobe ##1 s_rd(18'h3500) |=> prdata[4:0] == $past(lock_live, 2))
      else $error("lock status differs from strobed value");
   a_state_snap: assert property (s_strobe ##1 s_rd(18'h3504) |=> prdata[4:0] == $past(state_live, 2))
      else $error("loop state differs from strobed value");
   a_flag_snap: assert property (s_strobe ##1 s_rd(18'h3508) |=> prdata[2:0] == $past(flag_live, 2))
      else $error("loop flags differ from strobed value");
   a_lock_resv: assert property (s_rd(18'h3500) |=> prdata[31:5] == 27'h0)
      else $error("lock status upper bits set");
   a_state_resv: assert property (s_rd(18'h3504) |=> prdata[31:5] == 27'h0)
      else $error("loop state upper bits set");
   a_flag_resv: assert property (s_rd(18'h3508) |=> prdata[31:3] == 29'h0)
      else $error("loop flags upper bits set");
   a_slverr_idle: assert property (!(psel && penable) |-> !pslverr)
      else $error("pslverr outside access phase");
   a_ready_high: assert property (psel && penable |-> pready)
      else $error("pready low in access phase");
endmodule

// >>> tb/channel_status_regs_tb.sv
// Self-checking bench for the status readback block: APB master tasks and scenarios.
// Assumes the checker file is compiled first; drives every input of the block itself.
module channel_status_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [17:0] paddr = 18'h0;
   logic [31:0] pwdata = 32'h0, q;
   logic [12:0] lv = 13'h0;
   wire pready, pslverr, irq;
   wire [31:0] prdata;
   int error_cnt = 0, n_compared = 0;
   `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
      $display("mismatch %s exp %h got %h", nm, e, g); end end
   channel_status_regs dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
      .pslverr, .irq, .sysclk_mult_locked(lv[0]), .second_digital_loop_phase_locked(lv[1]),
      .second_digital_loop_freq_locked(lv[2]), .second_analog_loop_locked(lv[3]), .second_analog_loop_cal(lv[4]),
      .second_digital_loop_free_run(lv[5]), .second_digital_loop_holdover(lv[6]),
      .second_digital_loop_switching(lv[7]), .second_digital_loop_ref(lv[9:8]),
      .second_digital_loop_history_ready(lv[10]), .second_digital_loop_freq_clamped(lv[11]),
      .second_digital_loop_slew_limited(lv[12]));
   initial forever #2 sys_clk = ~sys_clk;
   task automatic end_of_test;
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // The request is left up after its access edge so the next transfer may follow at once.
   task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      q = prdata;
      err = pslverr;
   endtask
   task automatic idle(input int n);
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic snap(input logic [17:0] a);
      apb(1'b1, 18'h14, 32'h1);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic t_stale;
      lv <= 13'h1fff;
      apb(1'b0, 18'h3500, 32'h0);
      `CHK("stale", 32'h0, q)
      apb(1'b0, 18'h3540, 32'h0);
      `CHK("irq events", 32'h1e, q)
      apb(1'b1, 18'h14, 32'h2);
      apb(1'b0, 18'h3500, 32'h0);
      `CHK("bad strobe", 32'h0, q)
   endtask
   task automatic t_regs;
      for (int i = 0; i < 32; i++) begin
         lv[4:0] <= i[4:0];
         snap(18'h3500);
         `CHK("lock", {27'h0, i[4:1], i[0] & i[3] & i[1]}, q)
         lv[9:5] <= i[4:0];
         snap(18'h3504);
         `CHK("state", {27'h0, i[4:0]}, q)
         lv[12:10] <= i[2:0];
         snap(18'h3508);
         `CHK("flags", {29'h0, i[2:0]}, q)
      end
   endtask
   task automatic t_ro;
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 18'h3500 + 18'(4 * i), 32'hff);
         apb(1'b0, 18'h3500 + 18'(4 * i), 32'h0);
         `CHK("read only", (i == 2) ? 32'h7 : 32'h1f, q)
      end
      apb(1'b0, 18'h3600, 32'h0);
      `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped data", 32'h0, q)
   endtask
   task automatic t_irq;
      lv[10] <= 1'b0;
      apb(1'b1, 18'h3544, 32'h0);
      idle(4);
      apb(1'b1, 18'h3540, 32'h1f);
      lv[10] <= 1'b1;
      idle(4);
      `CHK("irq masked", 1'b0, irq)
      apb(1'b0, 18'h3540, 32'h0);
      `CHK("irq status", 32'h10, q)
      apb(1'b1, 18'h3544, 32'h10);
      idle(3);
      `CHK("irq raised", 1'b1, irq)
      apb(1'b1, 18'h3540, 32'h10);
      idle(3);
      `CHK("irq cleared", 1'b0, irq)
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      t_stale;
      t_regs;
      t_ro;
      t_irq;
      end_of_test;
   end
   initial begin
      #20000;
      error_cnt++;
      end_of_test;
   end
endmodule
bind channel_status_regs channel_status_regs_assertions u_chk (.*);
